//--- irq_route_pkg.sv
/*
 * Shared constants and carriers for the dual-core interrupt router:
 * second-level input numbers, sensitivities, first-level line numbers,
 * priorities and vector layout.
 * Assumes every source is a synchronous level on clk_i.
 */
package irq_route_pkg;

	// ------------------------------------------------------------------
	// host second-level handler
	// ------------------------------------------------------------------
	localparam int HOST_L2_USB_HOST = 6;
	localparam int HOST_L2_USB_GEN = 20;
	localparam int HOST_L2_LOW_POWER = 24;
	localparam int HOST_L2_RTC_PERIODIC = 25;
	localparam int HOST_L2_RTC_ALARM = 26;
	localparam int HOST_L2_USB_ISOCH = 29;
	localparam int HOST_L2_SP2_OVERFLOW = 31;
	localparam logic [31:0] HOST_L2_USED = 32'hA7100040;
	localparam logic [31:0] HOST_L2_EDGE = 32'h82000000;
	localparam int HOST_L1_FROM_L2 = 0;

	// ------------------------------------------------------------------
	// signal processor second-level handler
	// ------------------------------------------------------------------
	localparam int SP_L2_FRAME_ERR1 = 10;
	localparam int SP_L2_FRAME_ERR2 = 11;
	localparam logic [31:0] SP_L2_USED = 32'h00000C00;
	localparam logic [31:0] SP_L2_EDGE = 32'h00000000;

	// ------------------------------------------------------------------
	// signal processor first-level lines (flag/mask bit = line number)
	// ------------------------------------------------------------------
	localparam int SP_LINES = 24;
	localparam int SP_LINE_L2 = 3;
	localparam int SP_LINE_TRAFFIC_CTRL_ABORT_IRQ = 4;
	localparam int SP_LINE_MAILBOX1 = 5;
	localparam int SP_LINE_GPIO = 7;
	localparam int SP_LINE_SP_TIMER_THREE_IRQ = 8;
	localparam int SP_LINE_DMA1 = 9;
	localparam int SP_LINE_HOST = 10;
	localparam int SP_LINE_WATCHDOG = 13;
	localparam int SP_LINE_DMA5 = 15;
	localparam int SP_LINE_EXT_MEM = 16;
	localparam int SP_LINE_DMA0 = 18;
	localparam int SP_LINE_MAILBOX2 = 19;
	localparam int SP_LINE_SP_TIMER_ONE_IRQ = 23;
	localparam logic [23:0] SP_L1_USED = 24'h8DA7B8;
	localparam logic [19:0] SP_VEC_BASE = 20'hFFF00;
	localparam int SP_VEC_SHIFT = 3;
	localparam logic [4:0] SP_PRIO_NONE = 5'h1F;
	// fixed priority per line, smaller number wins
	localparam logic [4:0] SP_PRIO [0:23] = '{
		5'h1F, 5'h1F, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0A,
		5'h0B, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12, 5'h15, 5'h16,
		5'h04, 5'h08, 5'h0C, 5'h10, 5'h13, 5'h14, 5'h17, 5'h18};

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic req;
		logic [4:0] line;
		logic [19:0] vector;
		logic [4:0] prio;
	} sp_int_s;

	typedef struct packed {
		logic [31:0] prev;
		logic [31:0] latch;
		logic [31:0] pend;
		logic irq;
		logic [4:0] num;
	} l2_state_s;

	typedef struct packed {
		logic [23:0] prev;
		logic [23:0] flags;
		sp_int_s pres;
	} sp_l1_state_s;

	// lowest set bit number of a 32-bit vector, zero when none
	function automatic logic [4:0] lowest_set(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

endpackage

//--- l2_handler.sv
/*
 * Second-level interrupt handler: 32 inputs, per-input edge or level
 * sensitivity, mask, sticky edge latches and one combined output.
 * Assumes sources and controls are synchronous to clk_i.
 */
`timescale 1ns/1ps
module l2_handler #(
	parameter logic [31:0] USED = 32'h00000000,
	parameter logic [31:0] EDGE = 32'h00000000
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [31:0] src_i,
	input wire logic [31:0] mask_i,
	input wire logic [31:0] clr_i,
	output logic [31:0] pending_o,
	output logic irq_o,
	output logic [4:0] num_o
);
	irq_route_pkg::l2_state_s state_r;
	irq_route_pkg::l2_state_s state_nxt;
	logic [31:0] src;
	logic [31:0] act;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		src = src_i & USED; // RULE_24
		state_nxt.prev = src;
		// a new edge wins over a clear in the same cycle
		state_nxt.latch = (state_r.latch & ~clr_i) | (src & ~state_r.prev & EDGE); // RULE_05
		// level inputs pend only while held
		state_nxt.pend = ((src & ~EDGE) | state_nxt.latch) & USED; // RULE_06
		act = state_nxt.pend & ~mask_i;
		state_nxt.irq = |act;
		state_nxt.num = irq_route_pkg::lowest_set(act);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign pending_o = state_r.pend;
	assign irq_o = state_r.irq;
	assign num_o = state_r.num;
endmodule

//--- sp_prio_select.sv
/*
 * Fixed-priority selector for the signal processor first-level lines:
 * picks the active line with the smallest priority number.
 * Assumes inputs already combine flags and enables.
 */
`timescale 1ns/1ps
module sp_prio_select (
	input wire logic [23:0] active_i,
	output irq_route_pkg::sp_int_s sel_o
);
	always_comb begin
		sel_o.req = 1'b0;
		sel_o.line = 5'h00;
		sel_o.prio = irq_route_pkg::SP_PRIO_NONE;
		for (int i = 0; i < irq_route_pkg::SP_LINES; i++) begin
			if (active_i[i] && (irq_route_pkg::SP_PRIO[i] < sel_o.prio)) begin // RULE_23
				sel_o.req = 1'b1;
				sel_o.line = 5'(i);
				sel_o.prio = irq_route_pkg::SP_PRIO[i];
			end
		end
		sel_o.vector = irq_route_pkg::SP_VEC_BASE + {12'h000, sel_o.line, 3'h0}; // RULE_23
	end
endmodule

//--- irq_route.sv
/*
 * Dual-core interrupt source routing: host second-level handler feeding
 * host line 0, signal processor second-level handler feeding line 3,
 * and the signal processor first-level flags with fixed priorities.
 * Assumes all sources and controls are synchronous to clk_i.
 */
// What this block does
// [RULE_01] USB host level input 6; drives line 0
// [RULE_02] USB function general level on host input 20
// [RULE_03] USB isochronous-on level on host input 29
// [RULE_04] low-power module level on host input 24
// [RULE_05] RTC periodic edge on input 25, latched
// [RULE_06] RTC alarm level on input 26, pending only while held
// [RULE_07] serial port 2 overflow edge on input 31
// [RULE_08] processor second-level output drives line 3, priority 5
// [RULE_09] traffic abort on line 4, priority 6
// [RULE_10] mailbox 1 on line 5, priority 7
// [RULE_11] mailbox 2 on line 19, priority 16
// [RULE_12] timer 3 on line 8, priority 11
// [RULE_13] DMA channel 1 on line 9, priority 13
// [RULE_14] DMA channel 0 on line 18, priority 12
// [RULE_15] host interrupt on line 10, priority 14
// [RULE_16] watchdog on line 13, priority 18
// [RULE_17] external memory DMA on line 16, priority 4
// [RULE_18] shared GPIO on line 7, priority 10
// [RULE_19] frame error 1 level on second-level input 10
// [RULE_20] frame error 2 level on second-level input 11
// [RULE_21] timer 1 on line 23, priority 24
// [RULE_22] DMA channel 5 on line 15, priority 22
// [RULE_23] present smallest-priority pending line and vector
// [RULE_24] reserved inputs tied inactive regardless of mask
`timescale 1ns/1ps
module irq_route (
	input wire logic clk_i,
	input wire logic rstn_i,
	// host sources
	input wire logic usb_host_ctrl_irq_i,
	input wire logic usb_function_general_irq_i,
	input wire logic usb_function_isoch_on_irq_i,
	input wire logic low_power_module_irq_i,
	input wire logic rtc_periodic_irq_i,
	input wire logic rtc_alarm_irq_i,
	input wire logic serial_port2_rx_overflow_irq_i,
	input wire logic [31:0] host_l2_mask_i,
	input wire logic [31:0] host_l2_clr_i,
	output logic [31:0] host_l2_pending_o,
	output logic [4:0] host_l2_num_o,
	output logic [31:0] host_l1_irq_o,
	// signal processor second-level sources
	input wire logic mcs_if1_frame_err_irq_i,
	input wire logic mcs_if2_frame_err_irq_i,
	input wire logic [31:0] sp_l2_mask_i,
	input wire logic [31:0] sp_l2_clr_i,
	output logic [31:0] sp_l2_pending_o,
	output logic [4:0] sp_l2_num_o,
	// signal processor first-level sources
	input wire logic traffic_ctrl_abort_irq_i,
	input wire logic host_to_sp_mailbox1_irq_i,
	input wire logic host_to_sp_mailbox2_irq_i,
	input wire logic sp_gpio_irq_i,
	input wire logic sp_timer_three_irq_i,
	input wire logic sp_timer_one_irq_i,
	input wire logic sp_dma_ch0_irq_i,
	input wire logic sp_dma_ch1_irq_i,
	input wire logic sp_dma_ch5_irq_i,
	input wire logic host_to_sp_irq_i,
	input wire logic sp_watchdog_irq_i,
	input wire logic dma_ext_mem_if_irq_i,
	// flag/mask bits: enable 1 lets a flag through
	input wire logic [23:0] sp_mask_bits_i,
	input wire logic [23:0] sp_flag_clr_i,
	input wire logic sp_int_ack_i,
	output logic [23:0] sp_flag_mask_bits_o,
	output irq_route_pkg::sp_int_s sp_int_o
);
	logic [31:0] host_src;
	logic [31:0] sp_l2_src;
	logic host_l2_irq;
	logic sp_l2_out;
	logic [23:0] lines;
	logic [23:0] clr;
	logic [23:0] ack_bit;
	irq_route_pkg::sp_int_s sel;
	irq_route_pkg::sp_l1_state_s state_r;
	irq_route_pkg::sp_l1_state_s state_nxt;

	// ------------------------------------------------------------------
	// host second-level handler
	// ------------------------------------------------------------------
	always_comb begin
		host_src = 32'h00000000; // RULE_24
		host_src[irq_route_pkg::HOST_L2_USB_HOST] = usb_host_ctrl_irq_i; // RULE_01
		host_src[irq_route_pkg::HOST_L2_USB_GEN] = usb_function_general_irq_i; // RULE_02
		host_src[irq_route_pkg::HOST_L2_USB_ISOCH] = usb_function_isoch_on_irq_i; // RULE_03
		host_src[irq_route_pkg::HOST_L2_LOW_POWER] = low_power_module_irq_i; // RULE_04
		host_src[irq_route_pkg::HOST_L2_RTC_PERIODIC] = rtc_periodic_irq_i; // RULE_05
		host_src[irq_route_pkg::HOST_L2_RTC_ALARM] = rtc_alarm_irq_i; // RULE_06
		host_src[irq_route_pkg::HOST_L2_SP2_OVERFLOW] = serial_port2_rx_overflow_irq_i; // RULE_07
	end

	l2_handler #(
		.USED(irq_route_pkg::HOST_L2_USED),
		.EDGE(irq_route_pkg::HOST_L2_EDGE)
	) host_l2 (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.src_i(host_src),
		.mask_i(host_l2_mask_i),
		.clr_i(host_l2_clr_i),
		.pending_o(host_l2_pending_o),
		.irq_o(host_l2_irq),
		.num_o(host_l2_num_o)
	);

	// other host first-level inputs are outside this block
	always_comb begin
		host_l1_irq_o = 32'h00000000;
		host_l1_irq_o[irq_route_pkg::HOST_L1_FROM_L2] = host_l2_irq; // RULE_01
	end

	// ------------------------------------------------------------------
	// signal processor second-level handler
	// ------------------------------------------------------------------
	always_comb begin
		sp_l2_src = 32'h00000000; // RULE_24
		sp_l2_src[irq_route_pkg::SP_L2_FRAME_ERR1] = mcs_if1_frame_err_irq_i; // RULE_19
		sp_l2_src[irq_route_pkg::SP_L2_FRAME_ERR2] = mcs_if2_frame_err_irq_i; // RULE_20
	end

	l2_handler #(
		.USED(irq_route_pkg::SP_L2_USED),
		.EDGE(irq_route_pkg::SP_L2_EDGE)
	) sp_l2 (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.src_i(sp_l2_src),
		.mask_i(sp_l2_mask_i),
		.clr_i(sp_l2_clr_i),
		.pending_o(sp_l2_pending_o),
		.irq_o(sp_l2_out),
		.num_o(sp_l2_num_o)
	);

	// ------------------------------------------------------------------
	// signal processor first-level lines
	// ------------------------------------------------------------------
	always_comb begin
		lines = 24'h000000;
		lines[irq_route_pkg::SP_LINE_L2] = sp_l2_out; // RULE_08 RULE_19 RULE_20
		lines[irq_route_pkg::SP_LINE_TRAFFIC_CTRL_ABORT_IRQ] = traffic_ctrl_abort_irq_i; // RULE_09
		lines[irq_route_pkg::SP_LINE_MAILBOX1] = host_to_sp_mailbox1_irq_i; // RULE_10
		lines[irq_route_pkg::SP_LINE_MAILBOX2] = host_to_sp_mailbox2_irq_i; // RULE_11
		lines[irq_route_pkg::SP_LINE_SP_TIMER_THREE_IRQ] = sp_timer_three_irq_i; // RULE_12
		lines[irq_route_pkg::SP_LINE_DMA1] = sp_dma_ch1_irq_i; // RULE_13
		lines[irq_route_pkg::SP_LINE_DMA0] = sp_dma_ch0_irq_i; // RULE_14
		lines[irq_route_pkg::SP_LINE_HOST] = host_to_sp_irq_i; // RULE_15
		lines[irq_route_pkg::SP_LINE_WATCHDOG] = sp_watchdog_irq_i; // RULE_16
		lines[irq_route_pkg::SP_LINE_EXT_MEM] = dma_ext_mem_if_irq_i; // RULE_17
		lines[irq_route_pkg::SP_LINE_GPIO] = sp_gpio_irq_i; // RULE_18
		lines[irq_route_pkg::SP_LINE_SP_TIMER_ONE_IRQ] = sp_timer_one_irq_i; // RULE_21
		lines[irq_route_pkg::SP_LINE_DMA5] = sp_dma_ch5_irq_i; // RULE_22
		lines = lines & irq_route_pkg::SP_L1_USED; // RULE_24
	end

	// ------------------------------------------------------------------
	// flags, acknowledge and presentation
	// ------------------------------------------------------------------
	always_comb begin
		ack_bit = 24'h000000;
		if (sp_int_ack_i && state_r.pres.req) begin
			ack_bit[state_r.pres.line] = 1'b1;
		end
		clr = sp_flag_clr_i | ack_bit;
		state_nxt.prev = lines;
		// a rising request wins over a clear or acknowledge
		state_nxt.flags = (state_r.flags & ~clr) | (lines & ~state_r.prev);
		state_nxt.pres = sel;
	end

	sp_prio_select prio_sel (
		.active_i(state_nxt.flags & sp_mask_bits_i),
		.sel_o(sel)
	); // RULE_23 RULE_14 RULE_17

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_r.prev <= 24'h000000;
			state_r.flags <= 24'h000000;
			state_r.pres.req <= 1'b0;
			state_r.pres.line <= 5'h00;
			state_r.pres.vector <= irq_route_pkg::SP_VEC_BASE;
			state_r.pres.prio <= irq_route_pkg::SP_PRIO_NONE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sp_flag_mask_bits_o = state_r.flags;
	assign sp_int_o = state_r.pres;
endmodule

//--- irq_route_monitor.sv
/* checker for irq_route outputs.
   assumes synchronous reset rstn_i on clk_i; bound to every irq_route. */
`timescale 1ns/1ps
module irq_route_monitor (
	input logic clk_i,
	input logic rstn_i,
	input logic usb_host_ctrl_irq_i,
	input logic rtc_alarm_irq_i,
	input logic serial_port2_rx_overflow_irq_i,
	input logic mcs_if1_frame_err_irq_i,
	input logic dma_ext_mem_if_irq_i,
	input logic [31:0] host_l2_clr_i,
	input logic [31:0] sp_l2_mask_i,
	input logic [31:0] host_l2_pending_o,
	input logic [31:0] host_l1_irq_o,
	input logic [31:0] sp_l2_pending_o,
	input logic [23:0] sp_flag_mask_bits_o,
	input irq_route_pkg::sp_int_s sp_int_o
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	a_usb_host_pend: assert property (usb_host_ctrl_irq_i |=> host_l2_pending_o[6])
		else $error("usb host source not pending");
	a_l1_bit_zero: assert property (host_l1_irq_o[31:1] == 31'h0)
		else $error("host first-level bit other than 0 set");
	a_alarm_level: assert property (!rtc_alarm_irq_i |=> !host_l2_pending_o[26])
		else $error("alarm pending after source dropped");
	a_periodic_keep: assert property (host_l2_pending_o[25] && !host_l2_clr_i[25] |=> host_l2_pending_o[25])
		else $error("periodic latch lost without clear");
	a_overflow_edge: assert property ($rose(serial_port2_rx_overflow_irq_i) |=> host_l2_pending_o[31])
		else $error("overflow edge not latched");
	a_reserved_quiet: assert property ((host_l2_pending_o & ~irq_route_pkg::HOST_L2_USED) == 32'h0
		&& (sp_l2_pending_o & ~irq_route_pkg::SP_L2_USED) == 32'h0
		&& (sp_flag_mask_bits_o & ~irq_route_pkg::SP_L1_USED) == 24'h0)
		else $error("reserved input raised a request");
	a_frame_to_line: assert property ($rose(mcs_if1_frame_err_irq_i) && sp_l2_mask_i == 32'h0
		&& sp_l2_pending_o == 32'h0 |=> sp_l2_pending_o[10] ##1 sp_flag_mask_bits_o[3])
		else $error("frame error did not reach line 3");
	a_line16_flag: assert property ($rose(dma_ext_mem_if_irq_i) |=> sp_flag_mask_bits_o[16])
		else $error("line 16 flag not set");
	a_vector_form: assert property (sp_int_o.req |-> sp_flag_mask_bits_o[sp_int_o.line]
		&& sp_int_o.vector == (20'hFFF00 | (20'(sp_int_o.line) << 3)))
		else $error("presented line or vector wrong");

	c_line16: cover property (sp_int_o.req && sp_int_o.line == 5'h10);
	c_host_l1: cover property (host_l1_irq_o[0]);
	c_frame: cover property (sp_l2_pending_o[10]);
endmodule

bind irq_route irq_route_monitor mon (.clk_i, .rstn_i, .usb_host_ctrl_irq_i, .rtc_alarm_irq_i,
	.serial_port2_rx_overflow_irq_i, .mcs_if1_frame_err_irq_i, .dma_ext_mem_if_irq_i, .host_l2_clr_i,
	.sp_l2_mask_i, .host_l2_pending_o, .host_l1_irq_o, .sp_l2_pending_o, .sp_flag_mask_bits_o, .sp_int_o);

//--- irq_src_model.sv
/* peripheral sources model: each source is a registered level.
   assumes commands are driven on the rising edge of clk_i. */
`timescale 1ns/1ps
module irq_src_model (
	input wire logic clk_i,
	input wire logic [20:0] cmd_i,
	output logic [20:0] src_o
);
	// sources move just after an edge, one cycle after the command
	always_ff @(posedge clk_i) begin
		src_o <= cmd_i;
	end
endmodule

//--- irq_route_tb.sv
/* self-checking bench for irq_route.
   assumes irq_src_model drives the sources and the monitor is bound. */
`timescale 1ns/1ps
module irq_route_tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [20:0] cmd = 21'h0;
	logic [20:0] s;
	logic [31:0] hm = 32'h0, hc = 32'h0, sm2 = 32'h0, sc2 = 32'h0, hp, hl1, sp2;
	logic [23:0] em = 24'h0, fc = 24'h0, fl;
	logic ack = 1'b0;
	logic [4:0] hn, sn;
	irq_route_pkg::sp_int_s si;
	int failures = 0, cmp_count = 0;
	int hin[7] = '{6, 20, 29, 24, 25, 26, 31};
	int ln[12] = '{4, 5, 19, 8, 9, 18, 10, 13, 16, 7, 23, 15};
	int pr[12] = '{6, 7, 16, 11, 13, 12, 14, 18, 4, 10, 24, 22};
	int pl[3] = '{3, 18, 9};
	int pp[3] = '{5, 12, 13};

	irq_src_model src (.clk_i(clk_i), .cmd_i(cmd), .src_o(s));
	irq_route DUT (.clk_i(clk_i), .rstn_i(rstn_i),
		.usb_host_ctrl_irq_i(s[0]), .usb_function_general_irq_i(s[1]), .usb_function_isoch_on_irq_i(s[2]),
		.low_power_module_irq_i(s[3]), .rtc_periodic_irq_i(s[4]), .rtc_alarm_irq_i(s[5]),
		.serial_port2_rx_overflow_irq_i(s[6]), .host_l2_mask_i(hm), .host_l2_clr_i(hc),
		.host_l2_pending_o(hp), .host_l2_num_o(hn), .host_l1_irq_o(hl1),
		.mcs_if1_frame_err_irq_i(s[7]), .mcs_if2_frame_err_irq_i(s[8]), .sp_l2_mask_i(sm2),
		.sp_l2_clr_i(sc2), .sp_l2_pending_o(sp2), .sp_l2_num_o(sn),
		.traffic_ctrl_abort_irq_i(s[9]), .host_to_sp_mailbox1_irq_i(s[10]), .host_to_sp_mailbox2_irq_i(s[11]),
		.sp_timer_three_irq_i(s[12]), .sp_dma_ch1_irq_i(s[13]), .sp_dma_ch0_irq_i(s[14]),
		.host_to_sp_irq_i(s[15]), .sp_watchdog_irq_i(s[16]), .dma_ext_mem_if_irq_i(s[17]),
		.sp_gpio_irq_i(s[18]), .sp_timer_one_irq_i(s[19]), .sp_dma_ch5_irq_i(s[20]),
		.sp_mask_bits_i(em), .sp_flag_clr_i(fc), .sp_int_ack_i(ack),
		.sp_flag_mask_bits_o(fl), .sp_int_o(si));

	initial forever #20 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic step(input logic [20:0] v);
		@(posedge clk_i);
		cmd <= v;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	task automatic spx(input int l, p);
		chk(32'(si), {1'b0, 1'b1, 5'(l), 20'hFFF00 + 20'(8 * l), 5'(p)});
	endtask
	task automatic ackp;
		@(posedge clk_i);
		ack <= 1'b1;
		@(posedge clk_i);
		ack <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic clr;
		@(posedge clk_i);
		{hc, sc2, fc} <= '1;
		@(posedge clk_i);
		{hc, sc2, fc} <= '0;
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			step(21'h1 << i);
			chk(hp, 32'h1 << hin[i]);
			chk(hl1, 32'h1);
			chk(32'(hn), 32'(hin[i]));
			step(21'h0);
			chk(hp, (i == 4 || i == 6) ? 32'h1 << hin[i] : 32'h0);
			clr;
		end
		@(posedge clk_i);
		hm <= '1;
		step(21'h1);
		chk(hl1, 32'h0);
		chk(hp, 32'h40);
		@(posedge clk_i);
		hm <= '0;
		em <= '1;
		step(21'h0);
		$display("test host routing done");
		for (int i = 0; i < 12; i++) begin
			step(21'h200 << i);
			chk(32'(fl), 32'h1 << ln[i]);
			spx(ln[i], pr[i]);
			ackp;
			chk(32'(fl), 32'h0);
			step(21'h0);
		end
		$display("test line map done");
		for (int i = 0; i < 2; i++) begin
			step(21'h80 << i);
			chk(sp2, 32'h400 << i);
			chk(32'(sn), 32'(10 + i));
			spx(3, 5);
			step(21'h0);
			chk(sp2, 32'h0);
			clr;
		end
		$display("test second level done");
		@(posedge clk_i);
		em <= 24'hFEFFFF;
		step(21'h26080);
		for (int i = 0; i < 3; i++) begin
			spx(pl[i], pp[i]);
			ackp;
		end
		@(posedge clk_i);
		em <= '1;
		repeat (2) @(posedge clk_i);
		#1;
		spx(16, 4);
		$display("test priority done");
		step(21'h0);
		clr;
		// a rising source in the cycle of a clear must stay latched
		@(posedge clk_i);
		cmd <= 21'h20010;
		@(posedge clk_i);
		{hc, sc2, fc} <= '1;
		@(posedge clk_i);
		{hc, sc2, fc} <= '0;
		repeat (2) @(posedge clk_i);
		#1;
		chk(hp, 32'h02000000);
		chk(32'(fl), 32'h00010000);
		spx(16, 4);
		$display("test set over clear done");
		tally_and_finish;
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		tally_and_finish;
	end
endmodule
